// [common/uhps_regs.svh]
// Offsets, field positions, interrupt codes and counts of the serial controller.
// Contract
// - Device drives addressed register while read active.
// - Device stores bus data while write active.
// - High-strobe host ties low read strobe high.
// - High-strobe host ties low write strobe high.
// - Either strobe polarity performs the transfer.
// - Interrupt high only for enabled present source.
// - Sources: errors, data, empty, modem change.
// - Non-FIFO mode allows only DMA mode 0.
// - Mode 0 single transfers, mode 1 bursts.
// - Mode 0 receive request while data held.
// - Mode 1 receive request from trigger until empty.
// - Mode 1 transmit bursts until FIFO full.
// - Baud output is 16X generator clock.
// - Receiver samples on external 16X clock.
// - Board joins receive clock to baud output.
// - Drive disable low exactly while host reads; the code drives it low one cycle behind the read strobe.
// - Reset returns registers and outputs to reset.
// - Serial output and input disabled during reset.
// - User output A follows modem control bit 2.
// - User output B follows modem control bit 3.
// - Modem drives carrier detect low on carrier.
`ifndef UHPS_REGS_SVH
`define UHPS_REGS_SVH
`define UHPS_A_DATA 3'h0
`define UHPS_A_IER 3'h1
`define UHPS_A_ISR 3'h2
`define UHPS_A_LCR 3'h3
`define UHPS_A_MCR 3'h4
`define UHPS_A_LSR 3'h5
`define UHPS_A_MSR 3'h6
`define UHPS_A_SPR 3'h7
`define UHPS_FCR_EN 0
`define UHPS_FCR_RXCLR 1
`define UHPS_FCR_TXCLR 2
`define UHPS_FCR_DMA 3
`define UHPS_LCR_DLAB 7
`define UHPS_MCR_OUT_A 2
`define UHPS_MCR_OUT_B 3
`define UHPS_ISR_NONE 4'h1
`define UHPS_ISR_LS 4'h6
`define UHPS_ISR_RD 4'h4
`define UHPS_ISR_TO 4'hC
`define UHPS_ISR_TE 4'h2
`define UHPS_ISR_MS 4'h0
`define UHPS_TRIG0 1
`define UHPS_TRIG1 4
`define UHPS_TRIG2 8
`define UHPS_TRIG3 14
`define UHPS_FIFO_DEPTH 16
`define UHPS_RX_TMO_TICKS 10'h280
`define UHPS_H_CMD 4'h0
`define UHPS_H_STAT 4'h4
`define UHPS_H_CFG 4'h8
`define UHPS_H_STROBE_CYC 3
`endif

// [common/uhps_pkg.sv]
// Types shared by both ends of the serial controller pin link.
`default_nettype none
package uhps_pkg;
  typedef enum logic [1:0] {
    UHPS_R_IDLE = 2'b00,
    UHPS_R_START = 2'b01,
    UHPS_R_DATA = 2'b10,
    UHPS_R_STOP = 2'b11
  } uhps_rx_st_t;
  typedef enum logic {
    UHPS_T_IDLE = 1'b0,
    UHPS_T_SHIFT = 1'b1
  } uhps_tx_st_t;
  typedef enum logic [1:0] {
    UHPS_H_IDLE = 2'b00,
    UHPS_H_SETUP = 2'b01,
    UHPS_H_STROBE = 2'b10,
    UHPS_H_HOLD = 2'b11
  } uhps_hst_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
    logic bn;
  } uhps_baud_t;
  typedef struct packed {
    logic wreq;
    logic [31:0] rdat;
    uhps_hst_t st;
    logic [7:0] cnt;
    logic [2:0] haddr;
    logic [7:0] hdout;
    logic [7:0] last;
    logic isw, useh, cdp, hoe_n, rl, rh, wl, wh;
  } uhps_host_t;
endpackage
`default_nettype wire

// [common/uhps_if.sv]
// Pin-level link between the serial controller and its host.
`timescale 1ns/1ps
`default_nettype none
interface uhps_if;
  logic [2:0] addr;
  logic [7:0] h_dout;
  logic [7:0] d_dout;
  logic h_oe_n;
  logic d_oe_n;
  logic host_read_strobe_low;
  logic host_read_strobe_high;
  logic host_write_strobe_low;
  logic host_write_strobe_high;
  logic irq;
  logic rx_dma_request_n;
  logic tx_dma_request_n;
  logic read_drive_disable_n;
  logic user_output_a_n;
  logic user_output_b_n;
  logic baud_clk16_n;
  logic carrier_detect_n;
  wire [7:0] d;
  wire rx_clk16;
  // Pull-ups hold the data bus high while nobody drives it.
  assign d = !d_oe_n ? d_dout : (!h_oe_n ? h_dout : 8'hFF);
  assign rx_clk16 = baud_clk16_n;
  modport dev (
    input addr, d, host_read_strobe_low, host_read_strobe_high,
    input host_write_strobe_low, host_write_strobe_high, carrier_detect_n, rx_clk16,
    output d_dout, d_oe_n, irq, rx_dma_request_n, tx_dma_request_n,
    output read_drive_disable_n, user_output_a_n, user_output_b_n, baud_clk16_n
  );
  modport host (
    output addr, h_dout, h_oe_n, host_read_strobe_low, host_read_strobe_high,
    output host_write_strobe_low, host_write_strobe_high, carrier_detect_n,
    input d, irq, rx_dma_request_n, tx_dma_request_n, read_drive_disable_n,
    input user_output_a_n, user_output_b_n
  );
endinterface
`default_nettype wire

// [verilog/uhps_baud_gen.sv]
// Programmable divider making the 16X tick and the baud clock pin.
`timescale 1ns/1ps
`default_nettype none
module uhps_baud_gen
  import uhps_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_div,
  output logic o_tick,
  output logic o_baud_n
);
  uhps_baud_t q;
  uhps_baud_t n;
  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (i_div == 16'h0000) begin
      n.cnt = 16'h0000;
    end else if (q.cnt <= 16'h0001) begin
      n.cnt = i_div;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt - 16'h0001;
    end
    n.bn = (i_div == 16'h0000) || (n.cnt > (i_div >> 1));
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= '0;
      q.bn <= 1'b1;
    end else begin
      q <= n;
    end
  end
  assign o_tick = q.tick;
  assign o_baud_n = q.bn;
endmodule // uhps_baud_gen
`default_nettype wire

// [verilog/uhps_device.sv]
// Device end: registers, FIFOs, serial engines and host pin signalling.
`timescale 1ns/1ps
`default_nettype none
`include "uhps_regs.svh"
module uhps_device
  import uhps_pkg::*;
#(
  parameter int FIFO_DEPTH = `UHPS_FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  uhps_if.dev bus,
  input wire logic i_rx,
  output logic o_tx
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = AW + 1;
  if (FIFO_DEPTH != (1 << AW) || FIFO_DEPTH < 16) begin : g_chk
    $error("FIFO_DEPTH must be a power of two of at least 16.");
  end

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] rxm;
    logic [FIFO_DEPTH-1:0][7:0] txm;
    logic [AW-1:0] rxw, rxr, txw, txr;
    logic [CW-1:0] rxn, txn;
    logic [3:0] interrupt_enable_reg;
    logic [7:0] lcr, spr, dll, dlm, rdo, rsh;
    logic [4:0] modem_control_reg;
    logic fcr_en, dma1;
    logic [1:0] trig;
    logic oe, fe, thre_p, ddcd, cd_p, tmo_f, rxdma;
    logic doe_n, read_drive_disable_n_n, rd_p, wr_p, rclk_p;
    logic [2:0] ra;
    uhps_rx_st_t rst;
    logic [3:0] rcnt, tcnt, tbit;
    logic [2:0] rbit;
    logic [9:0] tmo, tsh;
    uhps_tx_st_t tst;
    logic txo, irq, rxdn, txdn, oa_n, ob_n;
  } uhps_dev_t;

  uhps_dev_t q;
  uhps_dev_t n;
  logic rd, wr, rxtk, btk, dlab, m1;
  logic rx_push, rx_pop, rx_clr, tx_push, tx_pop, tx_clr;
  logic [CW-1:0] cap;
  logic [7:0] rv;
  logic [3:0] isr_v;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] trig_lvl(input logic [1:0] t);
    unique case (t)
      2'h0: trig_lvl = CW'(`UHPS_TRIG0);
      2'h1: trig_lvl = CW'(`UHPS_TRIG1);
      2'h2: trig_lvl = CW'(`UHPS_TRIG2);
      2'h3: trig_lvl = CW'(`UHPS_TRIG3);
    endcase
  endfunction

  function automatic logic rx_avail(input uhps_dev_t s);
    rx_avail = s.fcr_en ? (s.rxn >= trig_lvl(s.trig)) : (s.rxn != '0);
  endfunction

  // Priority: line errors, time-out, data, transmit empty, modem.
  function automatic logic [3:0] isr_code(input uhps_dev_t s);
    if (s.interrupt_enable_reg[2] && (s.oe || s.fe)) isr_code = `UHPS_ISR_LS;
    else if (s.interrupt_enable_reg[0] && s.tmo_f) isr_code = `UHPS_ISR_TO;
    else if (s.interrupt_enable_reg[0] && rx_avail(s)) isr_code = `UHPS_ISR_RD;
    else if (s.interrupt_enable_reg[1] && s.thre_p) isr_code = `UHPS_ISR_TE;
    else if (s.interrupt_enable_reg[3] && s.ddcd) isr_code = `UHPS_ISR_MS;
    else isr_code = `UHPS_ISR_NONE;
  endfunction

  uhps_baud_gen u_baud (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_div({q.dlm, q.dll}),
    .o_tick(btk),
    .o_baud_n(bus.baud_clk16_n)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    rd = ~bus.host_read_strobe_low | bus.host_read_strobe_high;
    wr = ~bus.host_write_strobe_low | bus.host_write_strobe_high;
    dlab = q.lcr[`UHPS_LCR_DLAB];
    cap = q.fcr_en ? CW'(FIFO_DEPTH) : CW'(1);
    m1 = q.fcr_en & q.dma1;
    rxtk = bus.rx_clk16 & ~q.rclk_p;
    n.rclk_p = bus.rx_clk16;
    isr_v = isr_code(q);
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_clr = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_clr = 1'b0;
    unique case (bus.addr)
      `UHPS_A_DATA: rv = dlab ? q.dll : q.rxm[q.rxr];
      `UHPS_A_IER: rv = dlab ? q.dlm : {4'h0, q.interrupt_enable_reg};
      `UHPS_A_ISR: rv = {q.fcr_en, q.fcr_en, 2'h0, isr_v};
      `UHPS_A_LCR: rv = q.lcr;
      `UHPS_A_MCR: rv = {3'h0, q.modem_control_reg};
      `UHPS_A_LSR: rv = {1'b0, (q.txn == '0) && (q.tst == UHPS_T_IDLE), q.txn == '0,
                         1'b0, q.fe, 1'b0, q.oe, q.rxn != '0};
      `UHPS_A_MSR: rv = {~bus.carrier_detect_n, 3'h0, q.ddcd, 3'h0};
      `UHPS_A_SPR: rv = q.spr;
    endcase
    n.rdo = rd ? rv : q.rdo;
    n.doe_n = ~rd;
    n.read_drive_disable_n_n = ~rd;
    n.rd_p = rd;
    n.wr_p = wr;
    if (rd && !q.rd_p) n.ra = bus.addr;
    // Read side effects act when the strobe ends, so a held read sees stable data.
    if (q.rd_p && !rd) begin
      unique case (q.ra)
        `UHPS_A_DATA: begin
          if (!dlab && q.rxn != '0) rx_pop = 1'b1;
          n.tmo_f = 1'b0;
        end
        `UHPS_A_ISR: if (isr_code(q) == `UHPS_ISR_TE) n.thre_p = 1'b0;
        `UHPS_A_LSR: begin
          n.oe = 1'b0;
          n.fe = 1'b0;
        end
        `UHPS_A_MSR: n.ddcd = 1'b0;
        default: ;
      endcase
    end
    if (wr && !q.wr_p) begin
      unique case (bus.addr)
        `UHPS_A_DATA: begin
          if (dlab) n.dll = bus.d;
          else if (q.txn != cap) tx_push = 1'b1;
          n.thre_p = 1'b0;
        end
        `UHPS_A_IER: begin
          if (dlab) n.dlm = bus.d;
          else n.interrupt_enable_reg = bus.d[3:0];
          if (!dlab && bus.d[1] && !q.interrupt_enable_reg[1] && q.txn == '0) n.thre_p = 1'b1;
        end
        `UHPS_A_ISR: begin
          n.fcr_en = bus.d[`UHPS_FCR_EN];
          n.dma1 = bus.d[`UHPS_FCR_DMA];
          n.trig = bus.d[7:6];
          rx_clr = bus.d[`UHPS_FCR_RXCLR];
          tx_clr = bus.d[`UHPS_FCR_TXCLR];
        end
        `UHPS_A_LCR: n.lcr = bus.d;
        `UHPS_A_MCR: n.modem_control_reg = bus.d[4:0];
        `UHPS_A_SPR: n.spr = bus.d;
        default: ;
      endcase
    end
    // Receiver: start bit is checked at mid-bit, data sampled every 16 ticks.
    if (rxtk) begin
      n.rcnt = q.rcnt + 4'h1;
      unique case (q.rst)
        UHPS_R_IDLE: begin
          n.rcnt = 4'h0;
          if (!i_rx) n.rst = UHPS_R_START;
        end
        UHPS_R_START: if (q.rcnt == 4'h7) begin
          n.rcnt = 4'h0;
          n.rbit = 3'h0;
          n.rst = i_rx ? UHPS_R_IDLE : UHPS_R_DATA;
        end
        UHPS_R_DATA: if (q.rcnt == 4'hF) begin
          n.rsh = {i_rx, q.rsh[7:1]};
          n.rbit = q.rbit + 3'h1;
          if (q.rbit == 3'h7) n.rst = UHPS_R_STOP;
        end
        UHPS_R_STOP: if (q.rcnt == 4'hF) begin
          n.rst = UHPS_R_IDLE;
          if (!i_rx) n.fe = 1'b1;
          if (q.rxn == cap && !rx_pop) n.oe = 1'b1;
          else rx_push = 1'b1;
        end
      endcase
    end
    // Time-out: four character times of silence with data waiting.
    if (rx_push || rx_pop || q.rxn == '0 || !q.fcr_en) n.tmo = 10'h000;
    else if (rxtk && q.rst == UHPS_R_IDLE && q.tmo != `UHPS_RX_TMO_TICKS) n.tmo = q.tmo + 10'h001;
    if (q.tmo == `UHPS_RX_TMO_TICKS && q.rxn != '0) n.tmo_f = 1'b1;
    // Transmitter.
    unique case (q.tst)
      UHPS_T_IDLE: if (q.txn != '0 && !tx_clr) begin
        tx_pop = 1'b1;
        n.tsh = {1'b1, q.txm[q.txr], 1'b0};
        n.tcnt = 4'h0;
        n.tbit = 4'h0;
        n.tst = UHPS_T_SHIFT;
      end
      UHPS_T_SHIFT: if (btk) begin
        n.tcnt = q.tcnt + 4'h1;
        if (q.tcnt == 4'hF) begin
          n.tsh = {1'b1, q.tsh[9:1]};
          n.tbit = q.tbit + 4'h1;
          if (q.tbit == 4'h9) n.tst = UHPS_T_IDLE;
        end
      end
    endcase
    n.txo = (n.tst == UHPS_T_SHIFT) ? n.tsh[0] : 1'b1;
    // FIFO bookkeeping; a clear beats a simultaneous push or pop.
    if (rx_push) n.rxm[q.rxw] = q.rsh;
    n.rxw = rx_clr ? '0 : q.rxw + AW'(rx_push);
    n.rxr = rx_clr ? '0 : q.rxr + AW'(rx_pop);
    n.rxn = rx_clr ? '0 : CW'(q.rxn + CW'(rx_push) - CW'(rx_pop));
    if (tx_push) n.txm[q.txw] = bus.d;
    n.txw = tx_clr ? '0 : q.txw + AW'(tx_push);
    n.txr = tx_clr ? '0 : q.txr + AW'(tx_pop);
    n.txn = tx_clr ? '0 : CW'(q.txn + CW'(tx_push) - CW'(tx_pop));
    if (rx_clr) n.tmo_f = 1'b0;
    // Event flags are set last so an event wins over a same-cycle clear.
    if (q.txn != '0 && n.txn == '0) n.thre_p = 1'b1;
    n.cd_p = bus.carrier_detect_n;
    if (bus.carrier_detect_n != q.cd_p) n.ddcd = 1'b1;
    if (n.rxn == '0) n.rxdma = 1'b0;
    else if (rx_avail(n) || n.tmo_f) n.rxdma = 1'b1;
    n.rxdn = m1 ? ~n.rxdma : (n.rxn == '0);
    n.txdn = m1 ? (n.txn == cap) : (n.txn != '0);
    n.irq = (isr_code(n) != `UHPS_ISR_NONE);
    n.oa_n = ~n.modem_control_reg[`UHPS_MCR_OUT_A];
    n.ob_n = ~n.modem_control_reg[`UHPS_MCR_OUT_B];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= '0;
      q.doe_n <= 1'b1;
      q.read_drive_disable_n_n <= 1'b1;
      q.cd_p <= 1'b1;
      q.txo <= 1'b1;
      q.rxdn <= 1'b1;
      q.oa_n <= 1'b1;
      q.ob_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign bus.d_dout = q.rdo;
  assign bus.d_oe_n = q.doe_n;
  assign bus.read_drive_disable_n = q.read_drive_disable_n_n;
  assign bus.irq = q.irq;
  assign bus.rx_dma_request_n = q.rxdn;
  assign bus.tx_dma_request_n = q.txdn;
  assign bus.user_output_a_n = q.oa_n;
  assign bus.user_output_b_n = q.ob_n;
  assign o_tx = q.txo;
endmodule // uhps_device
`default_nettype wire

// [verilog/uhps_host.sv]
// Host end: Avalon-MM command registers driving device bus cycles.
`timescale 1ns/1ps
`default_nettype none
`include "uhps_regs.svh"
module uhps_host
  import uhps_pkg::*;
#(
  parameter int STROBE_CYCLES = `UHPS_H_STROBE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  uhps_if.host bus
);
  // Device read data is registered, so a strobe shorter than two cycles loses it.
  if (STROBE_CYCLES < 2 || STROBE_CYCLES > 255) begin : g_chk
    $error("STROBE_CYCLES must lie between 2 and 255.");
  end

  uhps_host_t q;
  uhps_host_t n;
  logic busy;
  logic act;

  always_comb begin
    n = q;
    busy = (q.st != UHPS_H_IDLE);
    n.wreq = 1'b1;
    if (q.wreq && (i_avs_read || i_avs_write) &&
        !(i_avs_write && busy && i_avs_address == `UHPS_H_CMD)) begin
      n.wreq = 1'b0;
      n.rdat = 32'h0000_0000;
      if (i_avs_read && i_avs_address == `UHPS_H_STAT) begin
        n.rdat = {17'h00000, bus.user_output_b_n, bus.user_output_a_n,
                  bus.read_drive_disable_n, bus.tx_dma_request_n,
                  bus.rx_dma_request_n, bus.irq, busy, q.last};
      end
      if (i_avs_read && i_avs_address == `UHPS_H_CFG) begin
        n.rdat = {30'h0000_0000, q.cdp, q.useh};
      end
    end
    if (!q.wreq && i_avs_write) begin
      if (i_avs_address == `UHPS_H_CMD) begin
        n.hdout = i_avs_writedata[7:0];
        n.haddr = i_avs_writedata[10:8];
        n.isw = i_avs_writedata[11];
        n.hoe_n = ~i_avs_writedata[11];
        n.st = UHPS_H_SETUP;
      end
      if (i_avs_address == `UHPS_H_CFG) begin
        n.useh = i_avs_writedata[0];
        n.cdp = i_avs_writedata[1];
      end
    end
    unique case (q.st)
      UHPS_H_IDLE: ;
      UHPS_H_SETUP: begin
        n.cnt = 8'h00;
        n.st = UHPS_H_STROBE;
      end
      UHPS_H_STROBE: begin
        n.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(STROBE_CYCLES - 1)) begin
          if (!q.isw) n.last = bus.d;
          n.st = UHPS_H_HOLD;
        end
      end
      UHPS_H_HOLD: begin
        n.hoe_n = 1'b1;
        n.st = UHPS_H_IDLE;
      end
    endcase
    act = (n.st == UHPS_H_STROBE);
    n.rl = ~(act && !n.isw && !n.useh);
    n.rh = act && !n.isw && n.useh;
    n.wl = ~(act && n.isw && !n.useh);
    n.wh = act && n.isw && n.useh;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= '0;
      q.wreq <= 1'b1;
      q.hoe_n <= 1'b1;
      q.rl <= 1'b1;
      q.wl <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign o_avs_readdata = q.rdat;
  assign o_avs_waitrequest = q.wreq;
  assign bus.addr = q.haddr;
  assign bus.h_dout = q.hdout;
  assign bus.h_oe_n = q.hoe_n;
  assign bus.host_read_strobe_low = q.rl;
  assign bus.host_read_strobe_high = q.rh;
  assign bus.host_write_strobe_low = q.wl;
  assign bus.host_write_strobe_high = q.wh;
  assign bus.carrier_detect_n = ~q.cdp;
endmodule // uhps_host
`default_nettype wire

// [test/uhps_props.sv]
// Concurrent checks on the pin link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module uhps_props (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] d,
  input wire logic [7:0] d_dout,
  input wire logic d_oe_n,
  input wire logic h_oe_n,
  input wire logic host_read_strobe_low,
  input wire logic host_read_strobe_high,
  input wire logic host_write_strobe_low,
  input wire logic host_write_strobe_high,
  input wire logic irq,
  input wire logic rx_dma_request_n,
  input wire logic tx_dma_request_n,
  input wire logic read_drive_disable_n,
  input wire logic user_output_a_n,
  input wire logic user_output_b_n,
  input wire logic baud_clk16_n,
  input wire logic rx_clk16
);
  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  wire logic rd_act;
  wire logic wr_act;
  assign rd_act = !host_read_strobe_low || host_read_strobe_high;
  assign wr_act = !host_write_strobe_low || host_write_strobe_high;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_read_done;
    rd_act [*2] ##1 !rd_act;
  endsequence
  sequence s_write_held;
    wr_act ##1 wr_act;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // disable follows drive.
  a_read_drive_disable_n_tracks_oe: assert property (read_drive_disable_n == d_oe_n)
    else $error("drive disable differs from device drive");
  a_read_drive_disable_n_needs_read: assert property (!read_drive_disable_n |-> $past(rd_act))
    else $error("drive disable low without a read");
  a_read_drive_disable_n_on_read: assert property (s_read_done |-> !read_drive_disable_n)
    else $error("drive disable high at end of read");
  a_read_data_bus: assert property (s_read_done |-> d == d_dout)
    else $error("bus does not carry device data on read");
  a_write_no_read_drive_disable_n: assert property (s_write_held |-> read_drive_disable_n)
    else $error("drive disable low during a write");
  a_single_driver: assert property (!d_oe_n |-> h_oe_n)
    else $error("host and device drive the bus together");
  a_rd_polarity: assert property (host_read_strobe_high |-> host_read_strobe_low)
    else $error("both read strobes active");
  a_wr_polarity: assert property (host_write_strobe_high |-> host_write_strobe_low)
    else $error("both write strobes active");
  a_rxclk_strap: assert property (rx_clk16 == baud_clk16_n)
    else $error("receive clock not joined to baud output");
  a_baud_period: assert property ($fell(baud_clk16_n) |-> ##[1:300] $rose(baud_clk16_n))
    else $error("baud clock stuck low");
  a_reset_state: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    i_rst |=> read_drive_disable_n && d_oe_n && !irq && rx_dma_request_n
    && user_output_a_n && user_output_b_n && baud_clk16_n)
    else $error("outputs not at reset values");
endmodule // uhps_props
`default_nettype wire

// [test/uart_host_pin_signalling_tb.sv]
// Self-checking bench for the host and device ends joined on the pin link.
`timescale 1ns/1ps
`default_nettype none
module uart_host_pin_signalling_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int CYCLE_LIMIT = 20000;
  logic sys_clk;
  logic rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  wire serial_line;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  uhps_if bus_if ();
  uhps_host uhps_host_inst (.i_sys_clk(sys_clk), .i_rst(rst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .bus(bus_if));
  // Serial loopback lets received data come from our own transmitter.
  uhps_device uhps_device_inst (.i_sys_clk(sys_clk), .i_rst(rst), .bus(bus_if),
    .i_rx(serial_line), .o_tx(serial_line));
  uhps_props uhps_props_inst (.i_sys_clk(sys_clk), .i_rst(rst), .d(bus_if.d),
    .d_dout(bus_if.d_dout), .d_oe_n(bus_if.d_oe_n), .h_oe_n(bus_if.h_oe_n),
    .host_read_strobe_low(bus_if.host_read_strobe_low),
    .host_read_strobe_high(bus_if.host_read_strobe_high),
    .host_write_strobe_low(bus_if.host_write_strobe_low),
    .host_write_strobe_high(bus_if.host_write_strobe_high), .irq(bus_if.irq),
    .rx_dma_request_n(bus_if.rx_dma_request_n), .tx_dma_request_n(bus_if.tx_dma_request_n),
    .read_drive_disable_n(bus_if.read_drive_disable_n),
    .user_output_a_n(bus_if.user_output_a_n), .user_output_b_n(bus_if.user_output_b_n),
    .baud_clk16_n(bus_if.baud_clk16_n), .rx_clk16(bus_if.rx_clk16));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low; only the timeout ends a hang.
  task automatic avm(input logic wr, input logic [3:0] a, input logic [31:0] v,
                     output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic stat(output logic [31:0] s);
    do begin
      avm(1'b0, 4'h4, 32'h0, s);
    end while (s[8] !== 1'b0);
  endtask
  task automatic dev_wr(input logic [2:0] a, input logic [7:0] v);
    logic [31:0] s;
    avm(1'b1, 4'h0, {20'h0, 1'b1, a, v}, s);
    stat(s);
  endtask
  task automatic dev_rd(input logic [2:0] a, output logic [7:0] v);
    logic [31:0] s;
    avm(1'b1, 4'h0, {20'h0, 1'b0, a, 8'h00}, s);
    stat(s);
    v = s[7:0];
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] s;
    stat(s);
    check8({2'h0, s[14:9]}, 8'h3A);
  endtask
  task automatic t_user_out;
    logic [31:0] s;
    logic [7:0] v;
    for (int i = 1; i < 5; i++) begin
      v = {4'h0, i[1:0], 2'b00};
      dev_wr(3'h4, v);
      stat(s);
      check8({6'h0, s[14:13]}, {6'h0, ~v[3], ~v[2]});
    end
  endtask
  task automatic t_strobes;
    logic [31:0] s;
    logic [7:0] v;
    for (int h = 0; h < 2; h++) begin
      avm(1'b1, 4'h8, {31'h0, h[0]}, s);
      dev_wr(3'h7, 8'h5A ^ {8{h[0]}});
      dev_rd(3'h7, v);
      check8(v, 8'h5A ^ {8{h[0]}});
    end
    avm(1'b1, 4'h8, 32'h0, s);
  endtask
  task automatic t_irq;
    logic [31:0] s;
    dev_wr(3'h1, 8'h02);
    stat(s);
    check8({7'h0, s[9]}, 8'h01);
    dev_wr(3'h1, 8'h00);
    stat(s);
    check8({7'h0, s[9]}, 8'h00);
  endtask
  // A carrier change is a modem source; reading the modem status clears the delta.
  task automatic t_modem;
    logic [31:0] s;
    logic [7:0] v;
    dev_wr(3'h1, 8'h08);
    avm(1'b1, 4'h8, 32'h2, s);
    stat(s);
    check8({7'h0, s[9]}, 8'h01);
    dev_rd(3'h6, v);
    check8(v, 8'h88);
    dev_rd(3'h6, v);
    check8(v, 8'h80);
    avm(1'b1, 4'h8, 32'h0, s);
    dev_wr(3'h1, 8'h00);
  endtask
  task automatic set_div(input logic [7:0] dv);
    dev_wr(3'h3, 8'h80);
    dev_wr(3'h0, dv);
    dev_wr(3'h1, 8'h00);
    dev_wr(3'h3, 8'h00);
  endtask
  task automatic t_serial;
    logic [31:0] s;
    logic [7:0] v;
    set_div(8'h04);
    dev_wr(3'h1, 8'h01);
    dev_wr(3'h0, 8'h3C);
    while (bus_if.rx_dma_request_n !== 1'b0) begin
      @(posedge sys_clk);
    end
    stat(s);
    check8({7'h0, s[9]}, 8'h01);
    dev_rd(3'h0, v);
    check8(v, 8'h3C);
    stat(s);
    check8({6'h0, s[10:9]}, 8'h02);
    dev_wr(3'h1, 8'h00);
  endtask
  // Trigger of four with one byte held: mode 1 waits for the time-out.
  task automatic t_rx_burst;
    logic [31:0] s;
    logic [7:0] v;
    dev_wr(3'h2, 8'h49);
    dev_wr(3'h0, 8'hA5);
    do begin
      dev_rd(3'h5, v);
    end while (v[0] !== 1'b1);
    stat(s);
    check8({7'h0, s[10]}, 8'h01);
    while (bus_if.rx_dma_request_n !== 1'b0) begin
      @(posedge sys_clk);
    end
    dev_rd(3'h0, v);
    check8(v, 8'hA5);
    stat(s);
    check8({7'h0, s[10]}, 8'h01);
  endtask
  // Divisor 0 stops the transmitter, so the first byte waits in the shifter and the second stays queued.
  task automatic t_dma;
    logic [31:0] s;
    set_div(8'h00);
    dev_wr(3'h2, 8'h01);
    dev_wr(3'h0, 8'h11);
    dev_wr(3'h0, 8'h22);
    stat(s);
    check8({7'h0, s[11]}, 8'h01);
    dev_wr(3'h2, 8'h09);
    stat(s);
    check8({7'h0, s[11]}, 8'h00);
  endtask
  // The stalled transmitter holds a start bit, so reset must lift the line.
  task automatic t_mid_reset;
    logic [31:0] s;
    dev_wr(3'h4, 8'h0C);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check8({7'h0, serial_line}, 8'h01);
    rst <= 1'b0;
    @(posedge sys_clk);
    stat(s);
    check8({2'h0, s[14:9]}, 8'h3A);
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_user_out();
    t_strobes();
    t_irq();
    t_modem();
    t_serial();
    t_rx_burst();
    t_dma();
    t_mid_reset();
    complete_run();
  end
endmodule // uart_host_pin_signalling_tb
`default_nettype wire
